// ===== rtl/kcrm_params.svh
/*
 * Address map, field positions, reset values and response codes of the
 * kernel control register bank.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef KCRM_PARAMS_SVH
`define KCRM_PARAMS_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define KCRM_OFS_CTRL 32'h0000_0000
`define KCRM_OFS_GIE 32'h0000_0004
`define KCRM_OFS_IER 32'h0000_0008
`define KCRM_OFS_ISR 32'h0000_000C
`define KCRM_OFS_ARG0 32'h0000_0010

// ***************************************************************
// Field positions
// ***************************************************************
`define KCRM_CTRL_START_BIT 0
`define KCRM_CTRL_DONE_BIT 1
`define KCRM_IRQ_BIT 0

// ***************************************************************
// Reset values, codes and sizes
// ***************************************************************
`define KCRM_WORD_RESET 32'h0000_0000
`define KCRM_RESP_OKAY 2'h0
`define KCRM_WORD_BYTES 32'h0000_0004
`define KCRM_SLOT_WORDS_PTR 2

`endif

// ===== rtl/kcrm_pkg.sv
/*
 * Types shared by the kernel control register bank.
 * Assumes the params header is on the include path.
 */
package kcrm_pkg;
    typedef logic [31:0] kcrm_word_type;
    typedef logic [3:0] kcrm_strb_type;
endpackage : kcrm_pkg

// ===== rtl/kcrm_regs.sv
/*
 * Kernel control register bank behind an AXI4-Lite slave port.
 * Assumes one clock, a synchronous active-high reset, and a kernel that
 * pulses TASK_FINISHED_I for one cycle when its task completes.
 */
`timescale 1ns/1ns
`include "kcrm_params.svh"

module kcrm_regs
    import kcrm_pkg::*;
#(
    parameter int NUM_SCALARS = 1,
    parameter int NUM_POINTERS = 2,
    parameter int ADDR_W = 12
)
(
    input wire logic REF_CLK_I,
    input wire logic SRST_I,
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic TASK_FINISHED_I,
    output logic KERNEL_START_O,
    output logic INTERRUPT_O,
    output logic [32*(NUM_SCALARS+2*NUM_POINTERS)-1:0] ARGS_O
);

    localparam int NUM_WORDS = NUM_SCALARS + `KCRM_SLOT_WORDS_PTR * NUM_POINTERS;

    // ***************************************************************
    // Elaboration checks
    // ***************************************************************
    initial
    begin
        if (NUM_SCALARS < 0 || NUM_POINTERS < 0 || NUM_WORDS < 1)
        begin
            $error("kcrm_regs: at least one argument word is needed");
        end
        if (ADDR_W < 5 || ADDR_W > 32 || (ADDR_W < 32 && 16 + 4 * NUM_WORDS > (2 ** ADDR_W)))
        begin
            $error("kcrm_regs: address width cannot hold the map");
        end
    end

    // ***************************************************************
    // State
    // ***************************************************************
    kcrm_word_type arg_mem [NUM_WORDS];
    logic ctrl_start;
    logic ctrl_done;
    kcrm_word_type gie;
    kcrm_word_type ier;
    logic isr;
    logic aw_ready;
    logic ar_ready;
    logic wr_fire;
    logic rd_fire;
    kcrm_word_type wr_addr;
    kcrm_word_type rd_addr;
    logic isr_event;
    logic isr_clear;
    logic ctrl_read;

    // ***************************************************************
    // Decode helpers
    // ***************************************************************
    function automatic logic is_arg(input kcrm_word_type a);
        is_arg = (a >= `KCRM_OFS_ARG0) &&
                 (a < `KCRM_OFS_ARG0 + 32'(NUM_WORDS) * `KCRM_WORD_BYTES);
    endfunction : is_arg

    function automatic int arg_index(input kcrm_word_type a);
        arg_index = int'((a - `KCRM_OFS_ARG0) >> 2);
    endfunction : arg_index

    function automatic kcrm_word_type merge(input kcrm_word_type old,
                                            input kcrm_word_type data,
                                            input kcrm_strb_type strb);
        kcrm_word_type r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[8*b +: 8] = data[8*b +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // Word-aligned addresses; byte offset bits are ignored
    assign wr_addr = 32'(S_AXI_AWADDR_I) & ~32'h0000_0003;
    assign rd_addr = 32'(S_AXI_ARADDR_I) & ~32'h0000_0003;
    assign wr_fire = aw_ready;
    assign rd_fire = ar_ready;
    assign isr_event = TASK_FINISHED_I && ier[`KCRM_IRQ_BIT];
    assign isr_clear = wr_fire && wr_addr == `KCRM_OFS_ISR && S_AXI_WSTRB_I[0] &&
                       S_AXI_WDATA_I[`KCRM_IRQ_BIT];
    assign ctrl_read = rd_fire && rd_addr == `KCRM_OFS_CTRL;

    // ***************************************************************
    // Write channel
    // ***************************************************************
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            aw_ready <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
        end
        else
        begin
            aw_ready <= S_AXI_AWVALID_I && S_AXI_WVALID_I && !aw_ready && !S_AXI_BVALID_O;
            if (wr_fire)
            begin
                S_AXI_BVALID_O <= 1'b1;
            end
            else if (S_AXI_BREADY_I)
            begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end
    assign S_AXI_AWREADY_O = aw_ready;
    assign S_AXI_WREADY_O = aw_ready;
    assign S_AXI_BRESP_O = `KCRM_RESP_OKAY;

    // ***************************************************************
    // Argument words
    // ***************************************************************
    generate
        for (genvar i = 0; i < NUM_WORDS; i++)
        begin : g_arg
            always_ff @(posedge REF_CLK_I)
            begin
                if (SRST_I)
                begin
                    arg_mem[i] <= `KCRM_WORD_RESET;
                end
                else if (wr_fire && is_arg(wr_addr) && arg_index(wr_addr) == i)
                begin
                    arg_mem[i] <= merge(arg_mem[i], S_AXI_WDATA_I, S_AXI_WSTRB_I);
                end
            end
            // Scalars first, one word each; then pointers as low and high words
            assign ARGS_O[32*i +: 32] = arg_mem[i];
        end
    endgenerate

    // ***************************************************************
    // Control and interrupt words
    // ***************************************************************
    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            ctrl_start <= 1'b0;
            ctrl_done <= 1'b0;
        end
        else
        begin
            if (TASK_FINISHED_I)
            begin
                ctrl_start <= 1'b0;
            end
            else if (wr_fire && wr_addr == `KCRM_OFS_CTRL && S_AXI_WSTRB_I[0])
            begin
                ctrl_start <= S_AXI_WDATA_I[`KCRM_CTRL_START_BIT];
            end
            if (TASK_FINISHED_I)
            begin
                ctrl_done <= 1'b1;
            end
            else if (ctrl_read)
            begin
                ctrl_done <= 1'b0;
            end
        end
    end
    assign KERNEL_START_O = ctrl_start;

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            gie <= `KCRM_WORD_RESET;
            ier <= `KCRM_WORD_RESET;
        end
        else if (wr_fire)
        begin
            if (wr_addr == `KCRM_OFS_GIE)
            begin
                gie <= merge(gie, S_AXI_WDATA_I, S_AXI_WSTRB_I);
            end
            if (wr_addr == `KCRM_OFS_IER)
            begin
                ier <= merge(ier, S_AXI_WDATA_I, S_AXI_WSTRB_I);
            end
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            isr <= 1'b0;
            INTERRUPT_O <= 1'b0;
        end
        else
        begin
            if (isr_event)
            begin
                isr <= 1'b1;
            end
            else if (isr_clear)
            begin
                isr <= 1'b0;
            end
            INTERRUPT_O <= gie[`KCRM_IRQ_BIT] && ier[`KCRM_IRQ_BIT] && isr;
        end
    end

    // ***************************************************************
    // Read channel
    // ***************************************************************
    function automatic kcrm_word_type read_word(input kcrm_word_type a);
        kcrm_word_type r;
        r = `KCRM_WORD_RESET;
        if (a == `KCRM_OFS_CTRL)
        begin
            r[`KCRM_CTRL_START_BIT] = ctrl_start;
            r[`KCRM_CTRL_DONE_BIT] = ctrl_done;
        end
        else if (a == `KCRM_OFS_GIE)
        begin
            r = gie;
        end
        else if (a == `KCRM_OFS_IER)
        begin
            r = ier;
        end
        else if (a == `KCRM_OFS_ISR)
        begin
            r[`KCRM_IRQ_BIT] = isr;
        end
        else if (is_arg(a))
        begin
            r = arg_mem[arg_index(a)];
        end
        read_word = r;
    endfunction : read_word

    always_ff @(posedge REF_CLK_I)
    begin
        if (SRST_I)
        begin
            ar_ready <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= `KCRM_WORD_RESET;
        end
        else
        begin
            ar_ready <= S_AXI_ARVALID_I && !ar_ready && !S_AXI_RVALID_O;
            if (rd_fire)
            begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O <= read_word(rd_addr);
            end
            else if (S_AXI_RREADY_I)
            begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end
    assign S_AXI_ARREADY_O = ar_ready;
    assign S_AXI_RRESP_O = `KCRM_RESP_OKAY;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    AST_IRQ_GATED: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        INTERRUPT_O |-> $past(gie[0]) && $past(ier[0]) && $past(isr))
        else $error("interrupt raised without both enables");
    AST_GIE_OFF: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        !gie[0] [*2] |-> !INTERRUPT_O)
        else $error("interrupt while global enable off");
    AST_ISR_SET: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        TASK_FINISHED_I && ier[0] |=> isr)
        else $error("enabled completion not pending");
    AST_ISR_MASKED: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        !isr && !(TASK_FINISHED_I && ier[0]) |=> !isr)
        else $error("status set without enabled event");
    AST_ISR_CLEAR: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        isr && isr_clear && !TASK_FINISHED_I |=> !isr)
        else $error("status not cleared by write of one");
    AST_ISR_STICKY: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        isr && !isr_clear |=> isr)
        else $error("status dropped without clear");
    AST_RD_RESERVED: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        rd_fire && rd_addr > `KCRM_OFS_ISR && !is_arg(rd_addr) |=> S_AXI_RDATA_O == 32'h0)
        else $error("reserved offset read not zero");
    AST_ARG_WRITE: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        wr_fire && wr_addr == `KCRM_OFS_ARG0 && S_AXI_WSTRB_I == 4'hF
        |=> arg_mem[0] == $past(S_AXI_WDATA_I))
        else $error("first argument word not written");
    AST_B_AFTER_W: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        wr_fire |=> S_AXI_BVALID_O && S_AXI_BRESP_O == `KCRM_RESP_OKAY)
        else $error("write not answered with OKAY");
    AST_CTRL_READ: assert property (@(posedge REF_CLK_I) disable iff (SRST_I)
        ctrl_read |=> S_AXI_RDATA_O[0] == $past(ctrl_start) && S_AXI_RDATA_O[31:2] == 30'h0)
        else $error("control word read wrong");

endmodule : kcrm_regs

// ===== test/kcrm_host.sv
/*
 * Host model: AXI4-Lite master for the register bank.
 * Assumes the bank samples on the rising edge of clk_i.
 */
`timescale 1ns/1ns
module kcrm_host
    import kcrm_pkg::*;
(
    input wire logic clk_i,
    output logic [11:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output kcrm_word_type wdata_o,
    output kcrm_strb_type wstrb_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic bvalid_i,
    output logic bready_o,
    output logic [11:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire kcrm_word_type rdata_i,
    input wire logic rvalid_i,
    output logic rready_o
);
    // *****************
    // Bus cycles
    // *****************
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end

    // Held until ready, released address and data show the inverse, strobes zero
    task wr(input logic [11:0] a, input kcrm_word_type d, input kcrm_strb_type s = 4'hF);
        @(posedge clk_i);
        #1;
        awaddr_o = a;
        wdata_o = d;
        wstrb_o = s;
        awvalid_o = 1'b1;
        wvalid_o = 1'b1;
        bready_o = 1'b1;
        do @(posedge clk_i); while (!(awready_i && wready_i));
        #1;
        awvalid_o = 1'b0;
        wvalid_o = 1'b0;
        awaddr_o = ~a;
        wdata_o = ~d;
        wstrb_o = 4'h0;
        // Ready held until an edge sees the response
        do @(posedge clk_i); while (!bvalid_i);
        #1;
        bready_o = 1'b0;
    endtask : wr

    task rd(input logic [11:0] a, output kcrm_word_type d);
        @(posedge clk_i);
        #1;
        araddr_o = a;
        arvalid_o = 1'b1;
        rready_o = 1'b1;
        do @(posedge clk_i); while (!arready_i);
        #1;
        arvalid_o = 1'b0;
        araddr_o = ~a;
        // Data taken at the edge that sees valid with ready high
        do @(posedge clk_i); while (!rvalid_i);
        d = rdata_i;
        #1;
        rready_o = 1'b0;
    endtask : rd
endmodule : kcrm_host

// ===== test/kernel_control_register_map_test.sv
/*
 * Self-checking bench for the kernel control register bank.
 * Assumes default parameters: one scalar and two pointer arguments.
 */
`timescale 1ns/1ns
module kernel_control_register_map_test;
    import kcrm_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic fin = 1'b0;
    logic [11:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, start, irq;
    kcrm_word_type wdata, rdata;
    kcrm_strb_type wstrb;
    logic [159:0] args;
    logic [1:0] bresp, rresp;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    kcrm_regs kcrm_regs_inst (.REF_CLK_I(clk), .SRST_I(srst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .TASK_FINISHED_I(fin),
        .KERNEL_START_O(start), .INTERRUPT_O(irq), .ARGS_O(args));

    kcrm_host kcrm_host_inst (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
        .wready_i(wready), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
        .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rvalid_i(rvalid),
        .rready_o(rready));

    // *****************
    // Helpers
    // *****************
    task chk(input kcrm_word_type got, input kcrm_word_type exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task rdchk(input logic [11:0] a, input kcrm_word_type exp);
        kcrm_word_type d;
        kcrm_host_inst.rd(a, d);
        chk(d, exp);
    endtask : rdchk

    task pulse_done;
        @(posedge clk);
        #1;
        fin = 1'b1;
        @(posedge clk);
        #1;
        fin = 1'b0;
    endtask : pulse_done

    task test_done;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // *****************
    // Scenarios
    // *****************
    task t_reset;
        for (int i = 0; i < 16; i += 4)
            rdchk(12'(i), 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask : t_reset

    task t_ctrl;
        kcrm_host_inst.wr(12'h000, 32'h0000_0001);
        chk({31'h0, start}, 32'h0000_0001);
        pulse_done();
        chk({31'h0, start}, 32'h0000_0000);
        rdchk(12'h000, 32'h0000_0002);
        rdchk(12'h000, 32'h0000_0000);
    endtask : t_ctrl

    task t_args;
        for (int i = 0; i < 5; i++)
            kcrm_host_inst.wr(12'h010 + 12'(4 * i), 32'hC0DE_0000 + 32'(i));
        for (int i = 0; i < 5; i++)
        begin
            rdchk(12'h010 + 12'(4 * i), 32'hC0DE_0000 + 32'(i));
            chk(args[32 * i +: 32], 32'hC0DE_0000 + 32'(i));
        end
        rdchk(12'h00C, 32'h0000_0000);
        kcrm_host_inst.wr(12'h010, 32'hFFFF_FFFF, 4'h2);
        rdchk(12'h010, 32'hC0DE_FF00);
        kcrm_host_inst.wr(12'h010, 32'hC0DE_0000);
        rdchk(12'h010, 32'hC0DE_0000);
    endtask : t_args

    task t_reserved;
        kcrm_host_inst.wr(12'h024, 32'hFFFF_FFFF);
        kcrm_host_inst.wr(12'hFFC, 32'hFFFF_FFFF);
        chk({30'h0, bresp}, 32'h0000_0000);
        rdchk(12'h024, 32'h0000_0000);
        rdchk(12'hFFC, 32'h0000_0000);
        chk({30'h0, rresp}, 32'h0000_0000);
        for (int i = 0; i < 5; i++)
            chk(args[32 * i +: 32], 32'hC0DE_0000 + 32'(i));
    endtask : t_reserved

    task t_irq;
        kcrm_host_inst.wr(12'h008, 32'h0000_0001);
        kcrm_host_inst.wr(12'h004, 32'h0000_0000);
        pulse_done();
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(12'h00C, 32'h0000_0001);
        kcrm_host_inst.wr(12'h004, 32'hFFFF_FFFF);
        rdchk(12'h004, 32'hFFFF_FFFF);
        chk({31'h0, irq}, 32'h0000_0001);
        kcrm_host_inst.wr(12'h00C, 32'h0000_0000);
        rdchk(12'h00C, 32'h0000_0001);
        kcrm_host_inst.wr(12'h00C, 32'h0000_0001);
        rdchk(12'h00C, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        kcrm_host_inst.wr(12'h008, 32'h0000_0000);
        rdchk(12'h008, 32'h0000_0000);
        pulse_done();
        rdchk(12'h00C, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
    endtask : t_irq

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            test_done();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        t_reset();
        t_ctrl();
        t_args();
        t_reserved();
        t_irq();
        test_done();
    end
endmodule : kernel_control_register_map_test
